/* logic/rtm_cfg.svh */
`ifndef RTM_CFG_SVH
`define RTM_CFG_SVH

// ----------------------------------------
// Structure
// ----------------------------------------
`define RTM_NCH 4
`define RTM_RES_W 18
`define RTM_TEMP_W 14
`define RTM_LIM_W 9
`define RTM_CORR_W 14
`define RTM_DB_W 6
`define RTM_PER_W 12
`define RTM_K_W 18
`define RTM_ACC_W 48

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTM_CLK_PERIOD_NS 40
`define RTM_INTEG_TIME_NS 1000000000
`define RTM_SEC_CYCLES (`RTM_INTEG_TIME_NS / `RTM_CLK_PERIOD_NS)

// ----------------------------------------
// Setting ranges and defaults
// ----------------------------------------
`define RTM_CORR_MAX 14'h2710
`define RTM_CORR_DEF 14'h0000
`define RTM_RANGE_LO_DEF 9'h032
`define RTM_RANGE_HI_DEF 9'h096
`define RTM_LOW_THR_DEF 9'h032
`define RTM_HIGH_THR_DEF 9'h064
`define RTM_DB_MIN 6'h01
`define RTM_DB_MAX 6'h32
`define RTM_DB_DEF 6'h01
`define RTM_PER_MAX 12'hE10
`define RTM_PER_DEF 12'h000
`define RTM_TEMP_SCALE 14'h000A
`define RTM_K_SHIFT 16

// ----------------------------------------
// Conversion: nominal centiohm, gain tenth degrees per centiohm with 16 fraction bits
// ----------------------------------------
`define RTM_R0_PT100 18'h02710
`define RTM_K_PT100 18'h0427E
`define RTM_R0_PT250 18'h061A8
`define RTM_K_PT250 18'h01A99
`define RTM_R0_PT1000 18'h186A0
`define RTM_K_PT1000 18'h006A6
`define RTM_R0_NI100 18'h02710
`define RTM_K_NI100 18'h0296D
`define RTM_R0_NI120 18'h02EE0
`define RTM_K_NI120 18'h02280
`define RTM_R0_NI250 18'h061A8
`define RTM_K_NI250 18'h01092
`define RTM_R0_NI1000 18'h186A0
`define RTM_K_NI1000 18'h00424
`define RTM_R0_NI120US 18'h02EE0
`define RTM_K_NI120US 18'h02618
`define RTM_R0_CU10 18'h003E8
`define RTM_K_CU10 18'h25788
`define RTM_R0_OHM 18'h00000
`define RTM_K_OHM 18'h0028F

`endif

/* logic/rtm_convert.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"

module rtm_convert
	import rtm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw measurement
	input wire logic res_valid,
	input wire logic [`RTM_RES_W-1:0] res,
	input wire logic [`RTM_RES_W-1:0] first_lead_resistance,
	// Settings
	input wire rtm_wiring_t wiring,
	input wire logic [`RTM_CORR_W-1:0] cable_corr,
	input wire rtm_sensor_t sensor_element_type,
	// Converted temperature
	rtm_meas_if.src meas
);

	localparam int PW = `RTM_RES_W + `RTM_K_W + 2;
	localparam logic signed [`RTM_TEMP_W-1:0] TMAX = {1'b0, {(`RTM_TEMP_W-1){1'b1}}};
	localparam logic signed [`RTM_TEMP_W-1:0] TMIN = {1'b1, {(`RTM_TEMP_W-1){1'b0}}};

	logic [`RTM_RES_W-1:0] sub;
	logic [`RTM_RES_W-1:0] comp_r;
	logic stage_r;
	rtm_sensor_t type_r;
	logic [`RTM_RES_W-1:0] r0;
	logic [`RTM_K_W-1:0] gain;
	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] scaled;

	// ----------------------------------------
	// Lead compensation
	// ----------------------------------------
	always_comb
	begin
		case (wiring)
			RTM_WIRE2: sub = `RTM_RES_W'(cable_corr);
			RTM_WIRE3: sub = {first_lead_resistance[`RTM_RES_W-2:0], 1'b0};
			default: sub = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			comp_r <= '0;
			stage_r <= 1'b0;
			type_r <= RTM_PT100;
		end
		else
		begin
			stage_r <= res_valid;
			if (res_valid)
			begin
				comp_r <= (res > sub) ? res - sub : '0;
				type_r <= sensor_element_type;
			end
		end
	end

	// ----------------------------------------
	// Resistance to temperature
	// ----------------------------------------
	// per-type conversion table
	always_comb
	begin
		case (type_r)
			RTM_PT100: begin r0 = `RTM_R0_PT100; gain = `RTM_K_PT100; end
			RTM_PT250: begin r0 = `RTM_R0_PT250; gain = `RTM_K_PT250; end
			RTM_PT1000: begin r0 = `RTM_R0_PT1000; gain = `RTM_K_PT1000; end
			RTM_NI100: begin r0 = `RTM_R0_NI100; gain = `RTM_K_NI100; end
			RTM_NI120: begin r0 = `RTM_R0_NI120; gain = `RTM_K_NI120; end
			RTM_NI250: begin r0 = `RTM_R0_NI250; gain = `RTM_K_NI250; end
			RTM_NI1000: begin r0 = `RTM_R0_NI1000; gain = `RTM_K_NI1000; end
			RTM_NI120US: begin r0 = `RTM_R0_NI120US; gain = `RTM_K_NI120US; end
			RTM_CU10: begin r0 = `RTM_R0_CU10; gain = `RTM_K_CU10; end
			RTM_SERVICE_OHM: begin r0 = `RTM_R0_OHM; gain = `RTM_K_OHM; end
			default: begin r0 = `RTM_R0_PT100; gain = `RTM_K_PT100; end
		endcase
	end

	assign prod = (PW'($signed({1'b0, comp_r})) - PW'($signed({1'b0, r0})))
		* PW'($signed({1'b0, gain}));
	assign scaled = prod >>> `RTM_K_SHIFT;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meas.valid <= 1'b0;
			meas.temp <= '0;
		end
		else
		begin
			meas.valid <= stage_r;
			if (stage_r)
			begin
				if (scaled > PW'(TMAX))
					meas.temp <= TMAX;
				else if (scaled < PW'(TMIN))
					meas.temp <= TMIN;
				else
					meas.temp <= scaled[`RTM_TEMP_W-1:0];
			end
		end
	end

endmodule // rtm_convert

`default_nettype wire

/* logic/rtm_limits.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"

module rtm_limits
	import rtm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Converted temperature
	rtm_meas_if.dst meas,
	// Limits in whole degrees
	input wire logic signed [`RTM_LIM_W-1:0] range_lower_limit,
	input wire logic signed [`RTM_LIM_W-1:0] range_upper_limit,
	input wire logic signed [`RTM_LIM_W-1:0] low_temperature_threshold,
	input wire logic signed [`RTM_LIM_W-1:0] high_temperature_threshold,
	// Flags
	output logic range_violation_flag,
	output logic low_alarm_flag,
	output logic high_alarm_flag
);

	function automatic logic signed [`RTM_TEMP_W-1:0] tenths
		(input logic signed [`RTM_LIM_W-1:0] v);
		tenths = `RTM_TEMP_W'(v) * $signed(`RTM_TEMP_SCALE);
	endfunction

	// ----------------------------------------
	// Flag update on each conversion
	// ----------------------------------------
	// level flags per conversion
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			range_violation_flag <= 1'b0;
			low_alarm_flag <= 1'b0;
			high_alarm_flag <= 1'b0;
		end
		else if (meas.valid)
		begin
			range_violation_flag <= (meas.temp < tenths(range_lower_limit))
				|| (meas.temp > tenths(range_upper_limit));
			low_alarm_flag <= meas.temp < tenths(low_temperature_threshold);
			high_alarm_flag <= meas.temp > tenths(high_temperature_threshold);
		end
	end

endmodule // rtm_limits

`default_nettype wire

/* logic/rtm_meas_if.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"

interface rtm_meas_if;
	logic valid;
	logic signed [`RTM_TEMP_W-1:0] temp;

	modport src (output valid, output temp);
	modport dst (input valid, input temp);
endinterface // rtm_meas_if

`default_nettype wire

/* logic/rtm_monitor.sv */
// Operation
// - Two-wire: subtract cable correction, 0..100 ohm
// - Three-wire: equal leads, no correction setting
// - Channels fully independent, own instance each
// - Temperature derived from measured resistance
// - Sensor type selects conversion, default PT100
// - Range_violation_flag flag outside min/max window
// - Low alarm while below low threshold
// - High alarm while above high threshold
// - Reports on value change or periodically
// - Report mode off/amplitude/integrated, off silences
// - Amplitude: report when deadband exceeded
// - Integrated: report when integral exceeds deadband-second
// - Periodic interval up to 3600 s, zero disables
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"

module rtm_monitor
	import rtm_pkg::*;
#(
	parameter int SEC_CYCLES = `RTM_SEC_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Resistance measurements, centiohm
	input wire logic [`RTM_NCH-1:0] res_valid,
	input wire logic [`RTM_NCH-1:0][`RTM_RES_W-1:0] res,
	input wire logic [`RTM_NCH-1:0][`RTM_RES_W-1:0] first_lead_resistance,
	// Wiring and sensor settings
	input wire rtm_wiring_t [`RTM_NCH-1:0] wiring,
	input wire logic [`RTM_NCH-1:0][`RTM_CORR_W-1:0] cable_corr,
	input wire rtm_sensor_t [`RTM_NCH-1:0] sensor_element_type,
	// Limit settings, whole degrees
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] range_lower_limit,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] range_upper_limit,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] low_temperature_threshold,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] high_temperature_threshold,
	// Report settings
	input wire rtm_rep_mode_t [`RTM_NCH-1:0] report_trigger_mode_setting,
	input wire logic [`RTM_NCH-1:0][`RTM_DB_W-1:0] deadband,
	input wire logic [`RTM_NCH-1:0][`RTM_PER_W-1:0] report_period,
	// Temperature, tenths of a degree
	output logic [`RTM_NCH-1:0] temp_valid,
	output logic [`RTM_NCH-1:0][`RTM_TEMP_W-1:0] temperature,
	// Flags
	output logic [`RTM_NCH-1:0] range_violation_flag,
	output logic [`RTM_NCH-1:0] low_alarm_flag,
	output logic [`RTM_NCH-1:0] high_alarm_flag,
	// Reports
	output logic [`RTM_NCH-1:0] report_strobe,
	output logic [`RTM_NCH-1:0][`RTM_TEMP_W-1:0] report_value
);

	localparam int AW = `RTM_ACC_W;
	localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

	// ----------------------------------------
	// Per-channel measuring instances
	// ----------------------------------------
	// one private instance per channel
	for (genvar ch = 0; ch < `RTM_NCH; ch++)
	begin : g_ch
		rtm_meas_if meas ();

		logic [31:0] sec_cnt_r;
		logic sec_tick;
		logic [`RTM_PER_W-1:0] per_cnt_r;
		logic per_hit;
		logic have_temp_r;
		logic signed [`RTM_TEMP_W-1:0] cur_r;
		logic signed [`RTM_TEMP_W-1:0] last_rep_r;
		logic signed [`RTM_TEMP_W:0] dev;
		logic [`RTM_TEMP_W:0] dev_abs;
		logic [`RTM_TEMP_W:0] db_tenths;
		logic amp_hit;
		logic signed [AW-1:0] acc_r;
		logic signed [AW-1:0] acc_nxt;
		logic [AW-1:0] acc_abs;
		logic [AW-1:0] int_thr;
		logic int_hit;
		logic fire;

		rtm_convert u_conv (
			.clk(clk),
			.rst_n(rst_n),
			.res_valid(res_valid[ch]),
			.res(res[ch]),
			.first_lead_resistance(first_lead_resistance[ch]),
			.wiring(wiring[ch]),
			.cable_corr(cable_corr[ch]),
			.sensor_element_type(sensor_element_type[ch]),
			.meas(meas.src)
		);

		rtm_limits u_lim (
			.clk(clk),
			.rst_n(rst_n),
			.meas(meas.dst),
			.range_lower_limit(range_lower_limit[ch]),
			.range_upper_limit(range_upper_limit[ch]),
			.low_temperature_threshold(low_temperature_threshold[ch]),
			.high_temperature_threshold(high_temperature_threshold[ch]),
			.range_violation_flag(range_violation_flag[ch]),
			.low_alarm_flag(low_alarm_flag[ch]),
			.high_alarm_flag(high_alarm_flag[ch])
		);

		// ----------------------------------------
		// Displayed temperature
		// ----------------------------------------
		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				temp_valid[ch] <= 1'b0;
				cur_r <= '0;
				have_temp_r <= 1'b0;
			end
			else
			begin
				temp_valid[ch] <= meas.valid;
				if (meas.valid)
				begin
					cur_r <= meas.temp;
					have_temp_r <= 1'b1;
				end
			end
		end

		assign temperature[ch] = cur_r;

		// ----------------------------------------
		// Seconds base
		// ----------------------------------------
		assign sec_tick = sec_cnt_r == SEC_LAST;

		always_ff @(posedge clk)
		begin
			if (!rst_n)
				sec_cnt_r <= '0;
			else if (sec_tick)
				sec_cnt_r <= '0;
			else
				sec_cnt_r <= sec_cnt_r + 32'h00000001;
		end

		// ----------------------------------------
		// Periodic trigger
		// ----------------------------------------
		// interval count, zero disables
		assign per_hit = sec_tick && (report_period[ch] != '0)
			&& (per_cnt_r + `RTM_PER_W'(1) >= report_period[ch]);

		always_ff @(posedge clk)
		begin
			if (!rst_n)
				per_cnt_r <= '0;
			else if (report_period[ch] == '0 || per_hit)
				per_cnt_r <= '0;
			else if (sec_tick)
				per_cnt_r <= per_cnt_r + `RTM_PER_W'(1);
		end

		// ----------------------------------------
		// Amplitude trigger
		// ----------------------------------------
		assign dev = (`RTM_TEMP_W+1)'(cur_r) - (`RTM_TEMP_W+1)'(last_rep_r);
		assign dev_abs = dev[`RTM_TEMP_W] ? `RTM_TEMP_W'(0) - dev : dev;
		assign db_tenths = (`RTM_TEMP_W+1)'(deadband[ch])
			* (`RTM_TEMP_W+1)'(`RTM_TEMP_SCALE);
		assign amp_hit = temp_valid[ch] && (dev_abs > db_tenths);

		// ----------------------------------------
		// Integrated trigger
		// ----------------------------------------
		// signed integral of deviation
		assign acc_nxt = have_temp_r ? acc_r + AW'(dev) : acc_r;
		assign acc_abs = acc_nxt[AW-1] ? AW'(0) - acc_nxt : acc_nxt;
		assign int_thr = AW'(db_tenths) * AW'(SEC_CYCLES);
		assign int_hit = acc_abs > int_thr;

		always_ff @(posedge clk)
		begin
			if (!rst_n)
				acc_r <= '0;
			else if (fire
				|| report_trigger_mode_setting[ch] != RTM_REP_INTEGRATED)
				acc_r <= '0;
			else
				acc_r <= acc_nxt;
		end

		// ----------------------------------------
		// Report decision
		// ----------------------------------------
		// change or periodic trigger
		always_comb
		begin
			case (report_trigger_mode_setting[ch])
				RTM_REP_AMPLITUDE: fire = amp_hit || per_hit;
				RTM_REP_INTEGRATED: fire = int_hit || per_hit;
				default: fire = 1'b0;
			endcase
		end

		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				report_strobe[ch] <= 1'b0;
				report_value[ch] <= '0;
				last_rep_r <= '0;
			end
			else
			begin
				report_strobe[ch] <= fire;
				if (fire)
				begin
					report_value[ch] <= cur_r;
					last_rep_r <= cur_r;
				end
			end
		end
	end

endmodule // rtm_monitor

`default_nettype wire

/* logic/rtm_pkg.sv */
package rtm_pkg;

	typedef enum logic [3:0] {
		RTM_PT100 = 4'h0,
		RTM_PT250 = 4'h1,
		RTM_PT1000 = 4'h2,
		RTM_NI100 = 4'h3,
		RTM_NI120 = 4'h4,
		RTM_NI250 = 4'h5,
		RTM_NI1000 = 4'h6,
		RTM_NI120US = 4'h7,
		RTM_CU10 = 4'h8,
		RTM_SERVICE_OHM = 4'h9
	} rtm_sensor_t;

	typedef enum logic [1:0] {
		RTM_WIRE2 = 2'h0,
		RTM_WIRE3 = 2'h1,
		RTM_WIRE4 = 2'h2
	} rtm_wiring_t;

	typedef enum logic [1:0] {
		RTM_REP_OFF = 2'h0,
		RTM_REP_AMPLITUDE = 2'h1,
		RTM_REP_INTEGRATED = 2'h2
	} rtm_rep_mode_t;

endpackage

/* verification/rtm_monitor_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"
module rtm_monitor_properties
	import rtm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`RTM_NCH-1:0] res_valid,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] range_lower_limit,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] range_upper_limit,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] low_temperature_threshold,
	input wire logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] high_temperature_threshold,
	input wire rtm_rep_mode_t [`RTM_NCH-1:0] report_trigger_mode_setting,
	input wire logic [`RTM_NCH-1:0][`RTM_DB_W-1:0] deadband,
	input wire logic [`RTM_NCH-1:0][`RTM_PER_W-1:0] report_period,
	input wire logic [`RTM_NCH-1:0] temp_valid,
	input wire logic [`RTM_NCH-1:0][`RTM_TEMP_W-1:0] temperature,
	input wire logic [`RTM_NCH-1:0] range_violation_flag,
	input wire logic [`RTM_NCH-1:0] low_alarm_flag,
	input wire logic [`RTM_NCH-1:0] high_alarm_flag,
	input wire logic [`RTM_NCH-1:0] report_strobe,
	input wire logic [`RTM_NCH-1:0][`RTM_TEMP_W-1:0] report_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int t, gap, dl;
	logic big;
	assign t = $signed(temperature[0]);
	assign gap = t - $signed(report_value[0]);
	assign dl = deadband[0] * 10;
	assign big = gap > dl || -gap > dl;
	property p_lat;
		temp_valid == $past(res_valid, 3);
	endproperty
	a_lat: assert property (p_lat)
		else $error("conversion latency wrong");
	property p_hold;
		temp_valid == '0 |-> $stable(temperature) && $stable(low_alarm_flag)
			&& $stable(high_alarm_flag) && $stable(range_violation_flag);
	endproperty
	a_hold: assert property (p_hold)
		else $error("flags moved without conversion");
	property p_high;
		temp_valid[0] |->
			high_alarm_flag[0] == (t > $signed(high_temperature_threshold[0]) * 10);
	endproperty
	a_high: assert property (p_high)
		else $error("high alarm wrong");
	property p_low;
		temp_valid[0] |->
			low_alarm_flag[0] == (t < $signed(low_temperature_threshold[0]) * 10);
	endproperty
	a_low: assert property (p_low)
		else $error("low alarm wrong");
	property p_range;
		temp_valid[0] |-> range_violation_flag[0] ==
			(t < $signed(range_lower_limit[0]) * 10
			|| t > $signed(range_upper_limit[0]) * 10);
	endproperty
	a_range: assert property (p_range)
		else $error("range flag wrong");
	property p_off;
		report_trigger_mode_setting[0] == RTM_REP_OFF
			&& $past(report_trigger_mode_setting[0]) == RTM_REP_OFF
			|-> !report_strobe[0];
	endproperty
	a_off: assert property (p_off)
		else $error("report while off");
	property p_amp;
		report_trigger_mode_setting[0] == RTM_REP_AMPLITUDE
			&& report_period[0] == '0 && temp_valid[0]
			|=> report_strobe[0] == $past(big);
	endproperty
	a_amp: assert property (p_amp)
		else $error("amplitude report wrong");
	property p_val;
		report_strobe[0] |-> report_value[0] == $past(temperature[0]);
	endproperty
	a_val: assert property (p_val)
		else $error("report value wrong");
endmodule // rtm_monitor_properties
bind rtm_monitor rtm_monitor_properties u_props (.clk, .rst_n, .res_valid,
	.range_lower_limit, .range_upper_limit, .low_temperature_threshold,
	.high_temperature_threshold, .report_trigger_mode_setting, .deadband,
	.report_period, .temp_valid, .temperature, .range_violation_flag,
	.low_alarm_flag, .high_alarm_flag, .report_strobe, .report_value);
`default_nettype wire

/* verification/rtm_monitor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"
module rtm_monitor_tb
	import rtm_pkg::*;
;
	localparam int SC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [`RTM_NCH-1:0] rv, tv, rvf, laf, haf, rs;
	logic [`RTM_NCH-1:0][`RTM_RES_W-1:0] res, lead;
	logic [`RTM_NCH-1:0][`RTM_CORR_W-1:0] corr;
	logic [`RTM_NCH-1:0][`RTM_LIM_W-1:0] lo, hi, lt, ht;
	logic [`RTM_NCH-1:0][`RTM_DB_W-1:0] db;
	logic [`RTM_NCH-1:0][`RTM_PER_W-1:0] per;
	logic [`RTM_NCH-1:0][`RTM_TEMP_W-1:0] temp, rval;
	rtm_wiring_t [`RTM_NCH-1:0] wir;
	rtm_sensor_t [`RTM_NCH-1:0] typ;
	rtm_rep_mode_t [`RTM_NCH-1:0] mode;
	int fails = 0;
	int compares = 0;
	logic [`RTM_RES_W-1:0] r0t [10] = '{`RTM_R0_PT100, `RTM_R0_PT250,
		`RTM_R0_PT1000, `RTM_R0_NI100, `RTM_R0_NI120, `RTM_R0_NI250,
		`RTM_R0_NI1000, `RTM_R0_NI120US, `RTM_R0_CU10, `RTM_R0_OHM};
	logic [`RTM_K_W-1:0] kt [10] = '{`RTM_K_PT100, `RTM_K_PT250,
		`RTM_K_PT1000, `RTM_K_NI100, `RTM_K_NI120, `RTM_K_NI250,
		`RTM_K_NI1000, `RTM_K_NI120US, `RTM_K_CU10, `RTM_K_OHM};
	always #20 clk = ~clk;
	rtm_sensor_model u_sens (.clk(clk), .res_valid(rv), .res(res));
	rtm_monitor #(.SEC_CYCLES(SC)) u_dut (.clk(clk), .rst_n(rst_n),
		.res_valid(rv), .res(res), .first_lead_resistance(lead),
		.wiring(wir), .cable_corr(corr), .sensor_element_type(typ),
		.range_lower_limit(lo), .range_upper_limit(hi),
		.low_temperature_threshold(lt), .high_temperature_threshold(ht),
		.report_trigger_mode_setting(mode), .deadband(db),
		.report_period(per), .temp_valid(tv), .temperature(temp),
		.range_violation_flag(rvf), .low_alarm_flag(laf),
		.high_alarm_flag(haf), .report_strobe(rs), .report_value(rval));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [`RTM_TEMP_W-1:0] exp_t(int ty, int rc);
		longint p;
		p = (longint'(rc) - longint'(r0t[ty])) * longint'(kt[ty]);
		return `RTM_TEMP_W'(p >>> `RTM_K_SHIFT);
	endfunction
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic meas(logic [`RTM_NCH-1:0] m, logic [`RTM_RES_W-1:0] r);
		u_sens.pulse(m, r);
		// Result stands one cycle, two edges after the sampling edge
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic cnt(int cyc, output int n);
		n = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			#1;
			if (rs[0] === 1'b1)
				n++;
		end
		@(negedge clk);
	endtask
	task automatic wrap_up();
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_types();
		for (int ty = 0; ty < 10; ty++)
		begin
			@(negedge clk);
			typ[0] = rtm_sensor_t'(ty);
			meas(4'h1, r0t[ty] + 18'h007D0);
			chk("temp_valid", tv[0], 1'b1);
			chk("type_temp", temp[0], exp_t(ty, r0t[ty] + 2000));
		end
		@(negedge clk);
		typ[0] = RTM_PT100;
	endtask
	task automatic t_wiring();
		// Pattern runs from channel 3 down to channel 0
		wir = '{RTM_WIRE4, RTM_WIRE3, RTM_WIRE2, RTM_WIRE4};
		corr[1] = `RTM_CORR_MAX;
		meas(4'hE, 18'h05D2A);
		chk("two_wire", temp[1], exp_t(0, 13850));
		chk("three_wire", temp[2], exp_t(0, 22850));
		chk("four_wire", temp[3], exp_t(0, 23850));
		meas(4'h2, 18'h01388);
		chk("corr_clamp", temp[1], exp_t(0, 0));
		chk("other_chan", temp[3], exp_t(0, 23850));
	endtask
	task automatic t_flags();
		int e;
		logic [`RTM_RES_W-1:0] rt [4] = '{18'h02580, 18'h038A4, 18'h03E80,
			18'h02580};
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk);
			if (i == 3)
				lo[0] = 9'h1EC;
			meas(4'h1, rt[i]);
			e = $signed(exp_t(0, rt[i]));
			chk("range", rvf[0], e < (i == 3 ? -200 : 500) || e > 1500);
			chk("low", laf[0], e < 500);
			chk("high", haf[0], e > 1000);
		end
	endtask
	task automatic t_report();
		int n, c, k;
		@(negedge clk);
		per[0] = 12'h001;
		cnt(3 * SC, n);
		chk("off_silent", n, 0);
		mode[0] = RTM_REP_AMPLITUDE;
		per[0] = 12'h000;
		meas(4'h1, 18'h02904);
		@(posedge clk);
		#1;
		chk("amp_strobe", rs[0], 1'b1);
		chk("amp_value", rval[0], exp_t(0, 10500));
		meas(4'h1, 18'h02918);
		@(posedge clk);
		#1;
		chk("amp_quiet", rs[0], 1'b0);
		k = 10 * SC / ($signed(exp_t(0, 10520)) - $signed(exp_t(0, 10500))) + 1;
		@(negedge clk);
		mode[0] = RTM_REP_INTEGRATED;
		c = 0;
		while (rs[0] !== 1'b1 && c < 1000)
		begin
			@(posedge clk);
			#1;
			c++;
		end
		chk("integ_time", c >= k - 1 && c <= k + 3, 1'b1);
		chk("integ_value", rval[0], exp_t(0, 10520));
		@(negedge clk);
		mode[0] = RTM_REP_AMPLITUDE;
		per[0] = 12'h001;
		cnt(5 * SC, n);
		chk("periodic", n >= 4 && n <= 6, 1'b1);
		per[0] = 12'h000;
		cnt(3 * SC, n);
		chk("period_zero", n, 0);
		mode[0] = RTM_REP_OFF;
	endtask
	initial
	begin
		typ = '{default: RTM_PT100};
		wir = '{default: RTM_WIRE4};
		mode = '{default: RTM_REP_OFF};
		lead = {4{18'h001F4}};
		corr = '0;
		lo = {4{`RTM_RANGE_LO_DEF}};
		hi = {4{`RTM_RANGE_HI_DEF}};
		lt = {4{`RTM_LOW_THR_DEF}};
		ht = {4{`RTM_HIGH_THR_DEF}};
		db = {4{`RTM_DB_DEF}};
		per = '0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_types();
		t_wiring();
		t_flags();
		t_report();
		wrap_up();
	end
	initial
	begin
		#(40 * 20000);
		fails++;
		wrap_up();
	end
endmodule // rtm_monitor_tb
`default_nettype wire

/* verification/rtm_sensor_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtm_cfg.svh"
// ----------------------------------------
// Resistance sensor front end
// ----------------------------------------
module rtm_sensor_model
(
	// Clock
	input wire logic clk,
	// Samples
	output logic [`RTM_NCH-1:0] res_valid,
	output logic [`RTM_NCH-1:0][`RTM_RES_W-1:0] res
);
	initial
	begin
		res_valid = '0;
		res = '0;
	end
	// One sample, lines scrambled once it is gone
	task automatic pulse(logic [`RTM_NCH-1:0] m, logic [`RTM_RES_W-1:0] r);
		@(negedge clk);
		res_valid = m;
		for (int i = 0; i < `RTM_NCH; i++)
			if (m[i])
				res[i] = r;
		@(negedge clk);
		res_valid = '0;
		res = ~res;
	endtask
endmodule // rtm_sensor_model
`default_nettype wire
